/* common/iapfc_consts.svh */
// Operation
// - Loader memory spans 0000H to 03FFH of region 02 only.
// - Loader memory holds two 512-byte sectors; erase clears one half.
// - Key n of at least 0x40 opens a window of n clock cycles.
// - Target address joins a low byte and a high byte register.
// - Region 0x00 sends reads and self-programming to the main array.
// - Region 0x01 reads the ID area only; other codes are reserved.
// - Full erase bit 6, then command 10, erases the 64K main array.
// - Sector bit 5, then command 10, erases the target's sector.
// - Program bit 4, then command 10, writes the data byte.
// - Only command 10 after an operation bit starts anything.
// - Reset fetches from loader when control bit 2 is one.
// - Writing one to power control bit 3 resets the CPU.
// - Read protection refuses external reads of main and loader.
// - Read protection clears only through complete reprogramming.
// - Read protection never blocks self-programming reads or writes.
// - A 96-bit unique code sits at 0260H to 026BH of region 01.
// - External programmer can check, program, verify, erase, read loader.
// - Window-size option limits self-programmed main flash, not in boot.
`ifndef IAPFC_CONSTS_SVH
`define IAPFC_CONSTS_SVH
`define IAPFC_OFS_PWR 8'h87
`define IAPFC_OFS_KEY 8'hf1
`define IAPFC_OFS_ADL 8'hf2
`define IAPFC_OFS_ADH 8'hf3
`define IAPFC_OFS_RGN 8'hf4
`define IAPFC_OFS_DAT 8'hf5
`define IAPFC_OFS_CTL 8'hf6
`define IAPFC_OFS_STS 8'hf7
`define IAPFC_RST_BYTE 8'h00
`define IAPFC_KEY_MIN 8'h40
`define IAPFC_BIT_FULL 6
`define IAPFC_BIT_SECT 5
`define IAPFC_BIT_PROG 4
`define IAPFC_BIT_SWRST 3
`define IAPFC_BIT_BOOT 2
`define IAPFC_CMD_GO 2'b10
`define IAPFC_CTL_MASK 8'h77
`define IAPFC_RGN_MAIN 8'h00
`define IAPFC_RGN_UID 8'h01
`define IAPFC_RGN_LDR 8'h02
`define IAPFC_LDR_TOP 16'h03ff
`define IAPFC_UID_LO 16'h0260
`define IAPFC_UID_HI 16'h026b
`define IAPFC_SECT_BITS 9
`endif

/* common/iapfc_pkg.sv */
package iapfc_pkg;
  typedef enum logic [2:0] {
    IAPFC_ST_IDLE = 3'b001,
    IAPFC_ST_OPEN = 3'b010,
    IAPFC_ST_BUSY = 3'b100
  } iapfc_state_e;
  typedef enum logic [1:0] {
    IAPFC_OP_PROG = 2'd0,
    IAPFC_OP_SECT = 2'd1,
    IAPFC_OP_FULL = 2'd2
  } iapfc_op_e;
  typedef struct packed {
    logic req;
    iapfc_op_e op;
    logic [7:0] region;
    logic [15:0] addr;
    logic [7:0] data;
  } iapfc_flash_req_s;
  typedef struct packed {
    iapfc_state_e st;
    logic [7:0] key;
    logic [7:0] win_cnt;
    logic [7:0] adl;
    logic [7:0] adh;
    logic [7:0] rgn;
    logic [7:0] dat;
    logic [7:0] ctl;
    logic ack;
    logic [31:0] rdat;
    logic cpu_rst;
    logic refused;
    logic busy_seen;
    iapfc_flash_req_s freq;
  } iapfc_state_s;
endpackage

/* design/iapfc_top.sv */
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "iapfc_consts.svh"
module iapfc_top
  import iapfc_pkg::*;
#(
  parameter int MAIN_AW = 16
) (
  input wire logic clk_sys, // System clock, 125 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [31:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  output logic wb_err_o, // Wishbone error, never raised.
  input wire logic [1:0] self_write_window_size, // Window-size option.
  input wire logic read_protect, // Read protection strap.
  input wire logic flash_done, // Flash array finished operation.
  output iapfc_flash_req_s flash_req_o, // Operation to flash array.
  output logic cpu_reset_o, // One-cycle CPU reset pulse.
  output logic boot_from_loader, // Boot source for the next reset.
  input wire logic [15:0] csr_addr_i, // Code-space read address.
  output logic [1:0] csr_target_o, // 0 main, 1 ID area, 2 loader.
  output logic csr_valid_o, // Code-space read address is legal.
  input wire logic ext_rd_req, // Debug link read request.
  input wire logic ext_rd_loader, // Debug link targets loader.
  output logic ext_rd_grant // Debug link read allowed.
);
  if (MAIN_AW != 16) begin : g_aw_check
    $error("Main array address must be 16 bits.");
  end

  ////////////////////////////////////////////////////////////////////////
  iapfc_state_s s_reg, s_next;
  logic [7:0] wr_byte;
  logic wr_hit;
  logic [7:0] wofs;
  logic [15:0] taddr;
  logic go;
  logic allowed;

  // Window-size option limits the main array; loader boot lifts it.
  function automatic logic main_ok(input logic [15:0] a,
                                   input logic [1:0] sz,
                                   input logic boot);
    logic ok;
    ok = 1'b1;
    if (!boot) begin
      case (sz)
        2'b00: ok = (a[15:10] == 6'h3f);
        2'b01: ok = (a[15:11] == 5'h1f);
        2'b10: ok = (a[15:12] == 4'hf);
        default: ok = 1'b1;
      endcase
    end
    return ok;
  endfunction

  assign wofs = wb_adr_i[9:2];
  assign wr_byte = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !s_reg.ack &&
                  wb_sel_i[0] && (wb_adr_i[31:10] == 22'h0);
  assign taddr = {s_reg.adh, s_reg.adl};

  always_comb begin
    s_next = s_reg;
    s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
    s_next.cpu_rst = 1'b0;
    s_next.refused = 1'b0;
    s_next.freq.req = 1'b0;
    s_next.rdat = 32'h0;
    go = 1'b0;
    allowed = 1'b0;
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !s_reg.ack &&
        wb_adr_i[31:10] == 22'h0) begin
      case (wofs)
        `IAPFC_OFS_KEY: s_next.rdat = {24'h0, s_reg.key};
        `IAPFC_OFS_ADL: s_next.rdat = {24'h0, s_reg.adl};
        `IAPFC_OFS_ADH: s_next.rdat = {24'h0, s_reg.adh};
        `IAPFC_OFS_RGN: s_next.rdat = {24'h0, s_reg.rgn};
        `IAPFC_OFS_DAT: s_next.rdat = {24'h0, s_reg.dat};
        `IAPFC_OFS_CTL: s_next.rdat = {24'h0, s_reg.ctl};
        `IAPFC_OFS_STS: s_next.rdat = {29'h0, s_reg.busy_seen,
                                      s_reg.st == IAPFC_ST_OPEN,
                                      s_reg.st == IAPFC_ST_BUSY};
        default: s_next.rdat = 32'h0; // Power control reads zero.
      endcase
    end
    // Window countdown; a write command ends it either way.
    if (s_reg.st == IAPFC_ST_OPEN) begin
      if (s_reg.win_cnt <= 8'd1) begin
        s_next.st = IAPFC_ST_IDLE;
        s_next.win_cnt = 8'h0;
      end else begin
        s_next.win_cnt = s_reg.win_cnt - 8'd1;
      end
    end
    if (s_reg.st == IAPFC_ST_BUSY && flash_done) begin
      s_next.st = IAPFC_ST_IDLE;
      s_next.ctl[1:0] = 2'b00;
      s_next.ctl[6:4] = 3'b000;
    end
    if (wr_hit) begin
      case (wofs)
        `IAPFC_OFS_PWR: s_next.cpu_rst = wr_byte[`IAPFC_BIT_SWRST];
        `IAPFC_OFS_KEY: begin
          s_next.key = wr_byte;
          if (wr_byte >= `IAPFC_KEY_MIN && s_reg.st != IAPFC_ST_BUSY) begin
            s_next.st = IAPFC_ST_OPEN;
            s_next.win_cnt = wr_byte;
          end
        end
        `IAPFC_OFS_ADL: s_next.adl = wr_byte;
        `IAPFC_OFS_ADH: s_next.adh = wr_byte;
        `IAPFC_OFS_RGN: s_next.rgn = wr_byte;
        `IAPFC_OFS_DAT: s_next.dat = wr_byte;
        `IAPFC_OFS_CTL: begin
          go = (wr_byte[1:0] == `IAPFC_CMD_GO) &&
               (s_reg.ctl[6:4] != 3'b000);
          if (go && s_reg.st != IAPFC_ST_OPEN) begin
            s_next.refused = 1'b1;
          end else if (s_reg.st != IAPFC_ST_BUSY) begin
            s_next.ctl = wr_byte & `IAPFC_CTL_MASK;
          end
          if (go && s_reg.st == IAPFC_ST_OPEN) begin
            s_next.freq.region = s_reg.rgn;
            s_next.freq.addr = taddr;
            s_next.freq.data = s_reg.dat;
            if (s_reg.ctl[`IAPFC_BIT_FULL]) begin
              s_next.freq.op = IAPFC_OP_FULL;
              allowed = (s_reg.rgn == `IAPFC_RGN_MAIN);
              s_next.freq.addr = 16'h0000;
            end else if (s_reg.ctl[`IAPFC_BIT_SECT]) begin
              s_next.freq.op = IAPFC_OP_SECT;
              s_next.freq.addr = {taddr[15:`IAPFC_SECT_BITS], 9'h000};
              allowed = 1'b1;
            end else begin
              s_next.freq.op = IAPFC_OP_PROG;
              allowed = 1'b1;
            end
            // The ID area is read-only; reserved regions do nothing.
            if (s_reg.rgn == `IAPFC_RGN_MAIN) begin
              allowed = allowed &&
                        main_ok(taddr, self_write_window_size,
                                s_reg.ctl[`IAPFC_BIT_BOOT]);
            end else if (s_reg.rgn == `IAPFC_RGN_LDR) begin
              allowed = allowed && (taddr <= `IAPFC_LDR_TOP);
            end else begin
              allowed = 1'b0;
            end
            s_next.win_cnt = 8'h0;
            if (allowed) begin
              s_next.freq.req = 1'b1;
              s_next.st = IAPFC_ST_BUSY;
              s_next.busy_seen = 1'b1;
            end else begin
              s_next.st = IAPFC_ST_IDLE;
              s_next.refused = 1'b1;
            end
          end
        end
        `IAPFC_OFS_STS: s_next.busy_seen = 1'b0;
        default: s_next.key = s_reg.key;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg <= '{st: IAPFC_ST_IDLE, freq: '{op: IAPFC_OP_PROG, default: '0},
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdat;
  assign wb_err_o = 1'b0;
  assign flash_req_o = s_reg.freq;
  assign cpu_reset_o = s_reg.cpu_rst;
  assign boot_from_loader = s_reg.ctl[`IAPFC_BIT_BOOT];

  // Code-space reads follow the region; protection does not apply here.
  always_comb begin
    csr_target_o = 2'd0;
    csr_valid_o = 1'b0;
    case (s_reg.rgn)
      `IAPFC_RGN_MAIN: begin
        csr_target_o = 2'd0;
        csr_valid_o = 1'b1;
      end
      `IAPFC_RGN_UID: begin
        csr_target_o = 2'd1;
        csr_valid_o = (csr_addr_i >= `IAPFC_UID_LO) &&
                      (csr_addr_i <= `IAPFC_UID_HI);
      end
      `IAPFC_RGN_LDR: begin
        csr_target_o = 2'd2;
        csr_valid_o = (csr_addr_i <= `IAPFC_LDR_TOP);
      end
      default: csr_valid_o = 1'b0;
    endcase
  end

  // Protection is a strap owned by the programmer; only a full
  // reprogramming outside this block can clear it.
  assign ext_rd_grant = ext_rd_req && !read_protect;

  ////////////////////////////////////////////////////////////////////////
  logic unused_ok;
  assign unused_ok = ext_rd_loader;

  property p_win_close;
    @(posedge clk_sys) disable iff (rst)
    (s_reg.st == IAPFC_ST_OPEN && s_reg.win_cnt == 8'd1 && !wr_hit)
      |=> s_reg.st == IAPFC_ST_IDLE;
  endproperty
  a_win_close: assert property (p_win_close)
    else $error("Window stayed open.");

  property p_no_closed_op;
    @(posedge clk_sys) disable iff (rst)
    (s_reg.st == IAPFC_ST_IDLE) |=> !flash_req_o.req;
  endproperty
  a_no_closed_op: assert property (p_no_closed_op)
    else $error("Op from closed window.");

  property p_uid_noop;
    @(posedge clk_sys) disable iff (rst)
    flash_req_o.req |-> flash_req_o.region != `IAPFC_RGN_UID;
  endproperty
  a_uid_noop: assert property (p_uid_noop)
    else $error("Write to ID area.");

  property p_sect_align;
    @(posedge clk_sys) disable iff (rst)
    (flash_req_o.req && flash_req_o.op == IAPFC_OP_SECT)
      |-> flash_req_o.addr[8:0] == 9'h000;
  endproperty
  a_sect_align: assert property (p_sect_align)
    else $error("Sector unaligned.");

  property p_ldr_range;
    @(posedge clk_sys) disable iff (rst)
    (flash_req_o.req && flash_req_o.region == `IAPFC_RGN_LDR)
      |-> flash_req_o.addr <= `IAPFC_LDR_TOP;
  endproperty
  a_ldr_range: assert property (p_ldr_range)
    else $error("Loader range.");

  property p_busy_after_req;
    @(posedge clk_sys) disable iff (rst)
    flash_req_o.req |-> s_reg.st == IAPFC_ST_BUSY && $past(wr_hit);
  endproperty
  a_busy_after_req: assert property (p_busy_after_req)
    else $error("Request without busy state.");

  property p_swrst;
    @(posedge clk_sys) disable iff (rst)
    (wr_hit && wofs == `IAPFC_OFS_PWR && wr_byte[`IAPFC_BIT_SWRST])
      |=> cpu_reset_o ##1 !cpu_reset_o;
  endproperty
  a_swrst: assert property (p_swrst)
    else $error("Soft reset missing.");

  property p_protect;
    @(posedge clk_sys) disable iff (rst)
    read_protect |-> !ext_rd_grant;
  endproperty
  a_protect: assert property (p_protect)
    else $error("Protected read granted.");

  property p_window_size;
    @(posedge clk_sys) disable iff (rst)
    (flash_req_o.req && flash_req_o.region == `IAPFC_RGN_MAIN &&
     flash_req_o.op == IAPFC_OP_PROG && self_write_window_size == 2'b00 &&
     !boot_from_loader) |-> flash_req_o.addr[15:10] == 6'h3f;
  endproperty
  a_window_size: assert property (p_window_size)
    else $error("Outside window size.");

  property p_full_main;
    @(posedge clk_sys) disable iff (rst)
    (flash_req_o.req && flash_req_o.op == IAPFC_OP_FULL)
      |-> flash_req_o.region == `IAPFC_RGN_MAIN && flash_req_o.addr == 16'h0;
  endproperty
  a_full_main: assert property (p_full_main)
    else $error("Full erase outside main array.");

  property p_rgn_legal;
    @(posedge clk_sys) disable iff (rst)
    flash_req_o.req |-> flash_req_o.region == `IAPFC_RGN_MAIN ||
                        flash_req_o.region == `IAPFC_RGN_LDR;
  endproperty
  a_rgn_legal: assert property (p_rgn_legal)
    else $error("Operation in reserved region.");

  property p_boot_hold;
    @(posedge clk_sys) disable iff (rst)
    !(wr_hit && wofs == `IAPFC_OFS_CTL) |=> $stable(boot_from_loader);
  endproperty
  a_boot_hold: assert property (p_boot_hold)
    else $error("Boot source changed without a write.");

  property p_req_data;
    @(posedge clk_sys) disable iff (rst)
    flash_req_o.req |-> flash_req_o.data == $past(s_reg.dat);
  endproperty
  a_req_data: assert property (p_req_data)
    else $error("Request data differs from data register.");

  property p_prog_addr;
    @(posedge clk_sys) disable iff (rst)
    (flash_req_o.req && flash_req_o.op == IAPFC_OP_PROG)
      |-> flash_req_o.addr == $past(taddr);
  endproperty
  a_prog_addr: assert property (p_prog_addr)
    else $error("Program address differs from target.");

  property p_cmd_only;
    @(posedge clk_sys) disable iff (rst)
    (wr_hit && wofs == `IAPFC_OFS_CTL && wr_byte[1:0] != `IAPFC_CMD_GO)
      |=> !flash_req_o.req;
  endproperty
  a_cmd_only: assert property (p_cmd_only)
    else $error("Reserved command started an operation.");

  property p_closed_keep;
    @(posedge clk_sys) disable iff (rst)
    (wr_hit && wofs == `IAPFC_OFS_CTL && s_reg.st == IAPFC_ST_IDLE &&
     wr_byte[1:0] == `IAPFC_CMD_GO && s_reg.ctl[6:4] != 3'b000)
      |=> $stable(s_reg.ctl);
  endproperty
  a_closed_keep: assert property (p_closed_keep)
    else $error("Closed trigger changed the control register.");

  property p_grant_open;
    @(posedge clk_sys) disable iff (rst)
    (ext_rd_req && !read_protect) |-> ext_rd_grant;
  endproperty
  a_grant_open: assert property (p_grant_open)
    else $error("Unprotected external read refused.");

  property p_win_open;
    @(posedge clk_sys) disable iff (rst)
    (wr_hit && wofs == `IAPFC_OFS_KEY && wr_byte >= `IAPFC_KEY_MIN &&
     s_reg.st != IAPFC_ST_BUSY) |=> s_reg.st == IAPFC_ST_OPEN;
  endproperty
  a_win_open: assert property (p_win_open)
    else $error("Key did not open the window.");
endmodule
`default_nettype wire

/* dv/iapfc_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iapfc_flash_model
  import iapfc_pkg::*;
#(
  parameter int BUSY_CYC = 5
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire iapfc_flash_req_s req_i, // Operation from the block.
  output logic done_o // One-cycle completion pulse.
);
  int cnt;
  // Every kind of operation takes the same busy time here.
  always_ff @(posedge clk_sys) begin
    done_o <= 1'b0;
    if (rst) begin
      cnt <= 0;
    end else if (req_i.req) begin
      cnt <= BUSY_CYC;
    end else if (cnt == 1) begin
      cnt <= 0;
      done_o <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

/* dv/iapfc_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "iapfc_consts.svh"
module iapfc_tb_top
  import iapfc_pkg::*;
;
  logic clk_sys, rst, cyc, stb, we, rp, ext_req, done, ack, err;
  logic cpu_rst, boot, csr_valid, grant;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel;
  logic [1:0] wsz, csr_tgt;
  logic [15:0] csr_addr;
  logic [7:0] rd;
  iapfc_flash_req_s freq, last_req;
  int fail_count, total_checks, req_cnt, rst_cnt, cyc_cnt;
  iapfc_top dut_u (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .self_write_window_size(wsz), .read_protect(rp), .flash_done(done),
    .flash_req_o(freq), .cpu_reset_o(cpu_rst), .boot_from_loader(boot),
    .csr_addr_i(csr_addr), .csr_target_o(csr_tgt), .csr_valid_o(csr_valid),
    .ext_rd_req(ext_req), .ext_rd_loader(boot), .ext_rd_grant(grant));
  iapfc_flash_model fl_u (.clk_sys(clk_sys), .rst(rst), .req_i(freq),
    .done_o(done));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (freq.req === 1'b1) begin
      req_cnt++;
      last_req = freq;
    end
    if (cpu_rst === 1'b1) rst_cnt++;
    if (cyc_cnt == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task chk(input string what, input logic [31:0] got, input logic [31:0] e);
    total_checks++;
    if (got !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask
  // Requests are held until ack is seen high at a rising edge.
  task wb(input logic w, input logic [7:0] ofs, input logic [7:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h0, ofs, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task go(input logic [7:0] rg, input logic [15:0] a, input logic [7:0] bits,
          input logic [1:0] cmd, input int ok, input iapfc_op_e eop);
    int n0;
    n0 = req_cnt;
    wb(1'b1, `IAPFC_OFS_RGN, rg);
    wb(1'b1, `IAPFC_OFS_ADH, a[15:8]);
    wb(1'b1, `IAPFC_OFS_ADL, a[7:0]);
    wb(1'b1, `IAPFC_OFS_DAT, 8'h5a);
    wb(1'b1, `IAPFC_OFS_KEY, 8'h40);
    wb(1'b1, `IAPFC_OFS_CTL, bits);
    wb(1'b1, `IAPFC_OFS_CTL, bits | {6'h0, cmd});
    repeat (12) @(posedge clk_sys);
    chk("trigger count", 32'(req_cnt - n0), 32'(ok));
    if (ok == 1) begin
      chk("op kind", 32'(last_req.op), 32'(eop));
      chk("region", 32'(last_req.region), 32'(rg));
      if (eop == IAPFC_OP_PROG) begin
        chk("data", 32'(last_req.data), 32'h5a);
        chk("address", 32'(last_req.addr), 32'(a));
      end
      if (eop == IAPFC_OP_SECT) begin
        chk("sector", 32'(last_req.addr), {16'h0, a[15:9], 9'h0});
      end
    end
  endtask
  task cs(input logic [15:0] a, input logic [1:0] t, input logic v);
    @(posedge clk_sys);
    csr_addr <= a;
    @(posedge clk_sys);
    chk("csr valid", 32'(csr_valid), 32'(v));
    if (v) chk("csr target", 32'(csr_tgt), 32'(t));
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_reset;
    for (int i = 1; i < 7; i++) begin
      wb(1'b0, 8'hf0 + 8'(i), 8'h00);
      chk("reset value", 32'(rd), 32'h0);
    end
    wb(1'b0, `IAPFC_OFS_PWR, 8'h00);
    chk("write-only read", 32'(rd), 32'h0);
    chk("bus error", 32'(err), 32'h0);
    wb(1'b0, 8'h10, 8'h00);
    chk("unmapped read", 32'(rd), 32'h0);
    $display("test reset done");
  endtask
  task t_ops;
    rp <= 1'b1; // Protection must not touch self-programming.
    go(8'h00, 16'h1234, 8'h10, 2'b10, 1, IAPFC_OP_PROG);
    wb(1'b0, `IAPFC_OFS_CTL, 8'h00);
    chk("ctl after op", 32'(rd), 32'h0);
    go(8'h02, 16'h0234, 8'h20, 2'b10, 1, IAPFC_OP_SECT);
    go(8'h02, 16'h0234, 8'h10, 2'b10, 1, IAPFC_OP_PROG);
    go(8'h00, 16'h8000, 8'h40, 2'b10, 1, IAPFC_OP_FULL);
    go(8'h02, 16'h0400, 8'h10, 2'b10, 0, IAPFC_OP_PROG);
    go(8'h01, 16'h0260, 8'h10, 2'b10, 0, IAPFC_OP_PROG);
    go(8'h03, 16'h0000, 8'h10, 2'b10, 0, IAPFC_OP_PROG);
    for (int c = 0; c < 4; c++) begin
      if (c != 2) begin
        go(8'h00, 16'h0100, 8'h10, 2'(c), 0, IAPFC_OP_PROG);
      end
    end
    $display("test operations done");
  endtask
  task t_window;
    int n0;
    n0 = req_cnt;
    wb(1'b1, `IAPFC_OFS_KEY, 8'h40);
    repeat (70) @(posedge clk_sys);
    wb(1'b1, `IAPFC_OFS_CTL, 8'h10);
    wb(1'b1, `IAPFC_OFS_CTL, 8'h12);
    wb(1'b0, `IAPFC_OFS_CTL, 8'h00);
    chk("closed trigger ctl", 32'(rd), 32'h10);
    chk("closed trigger count", 32'(req_cnt - n0), 32'h0);
    wb(1'b1, `IAPFC_OFS_KEY, 8'hff);
    repeat (100) @(posedge clk_sys);
    wb(1'b1, `IAPFC_OFS_CTL, 8'h12);
    repeat (2) @(posedge clk_sys);
    chk("long window op", 32'(last_req.addr), 32'h0100);
    chk("long window count", 32'(req_cnt - n0), 32'h1);
    repeat (10) @(posedge clk_sys);
    $display("test window done");
  endtask
  task t_size;
    wsz <= 2'b00;
    go(8'h00, 16'hf000, 8'h10, 2'b10, 0, IAPFC_OP_PROG);
    go(8'h00, 16'hfc00, 8'h10, 2'b10, 1, IAPFC_OP_PROG);
    go(8'h00, 16'hf000, 8'h14, 2'b10, 1, IAPFC_OP_PROG);
    wsz <= 2'b01;
    go(8'h00, 16'hf7ff, 8'h10, 2'b10, 0, IAPFC_OP_PROG);
    go(8'h00, 16'hf800, 8'h10, 2'b10, 1, IAPFC_OP_PROG);
    wsz <= 2'b10;
    go(8'h00, 16'hf000, 8'h10, 2'b10, 1, IAPFC_OP_PROG);
    wsz <= 2'b11;
    $display("test window size done");
  endtask
  task t_misc;
    int n0;
    n0 = rst_cnt;
    wb(1'b1, `IAPFC_OFS_PWR, 8'hf7);
    wb(1'b1, `IAPFC_OFS_PWR, 8'h08);
    repeat (3) @(posedge clk_sys);
    chk("cpu resets", 32'(rst_cnt - n0), 32'h1);
    wb(1'b1, `IAPFC_OFS_CTL, 8'h04);
    repeat (2) @(posedge clk_sys);
    chk("boot source", 32'(boot), 32'h1);
    ext_req <= 1'b1;
    cs(16'h1234, 2'd0, 1'b1);
    chk("protected grant", 32'(grant), 32'h0);
    rp <= 1'b0;
    wb(1'b1, `IAPFC_OFS_RGN, `IAPFC_RGN_UID);
    chk("open grant", 32'(grant), 32'h1);
    cs(16'h0260, 2'd1, 1'b1);
    cs(16'h026b, 2'd1, 1'b1);
    cs(16'h026c, 2'd1, 1'b0);
    wb(1'b1, `IAPFC_OFS_RGN, `IAPFC_RGN_LDR);
    cs(16'h03ff, 2'd2, 1'b1);
    cs(16'h0400, 2'd2, 1'b0);
    wb(1'b1, `IAPFC_OFS_RGN, `IAPFC_RGN_MAIN);
    wb(1'b1, `IAPFC_OFS_CTL, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("boot source", 32'(boot), 32'h0);
    $display("test misc done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {cyc, stb, we, rp, ext_req} = '0;
    {adr, wdat, csr_addr} = '0;
    rst = 1'b1;
    sel = 4'h1;
    wsz = 2'b11;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_ops();
    t_window();
    t_size();
    t_misc();
    report_and_stop();
  end
endmodule
`default_nettype wire
